// ===== logic/xop_defines.svh
/*
 * Opcode fields, data addresses and timing counts for the extended-op decoder.
 * Assumes inclusion once per compilation unit.
 */
`ifndef XOP_DEFINES_SVH
`define XOP_DEFINES_SVH

`define XOP_OPC_ADDPTR 8'he8
`define XOP_OPC_MOVE 8'heb
`define XOP_OPC_CALLACC 16'h0014
`define XOP_SECOND_NIBBLE 4'hf
`define XOP_SEL_RETURN 2'b11
`define XOP_PC_STEP 21'h000002
`define XOP_INDIRECT_VALUE 8'h00
// Indirect register window: four bytes (base..base+3) from 0fefh, 0fe7h or 0fdfh, one per pointer
`define XOP_IND_BASE0 12'hfef
`define XOP_IND_BASE1 12'hfe7
`define XOP_IND_BASE2 12'hfdf
`define XOP_IND_SPAN 12'h004
`define XOP_LAST_PHASE 2'd3

`endif

// ===== logic/xop_pkg.sv
/*
 * Types shared by the extended-op decoder.
 * Assumes the defines header is compiled alongside.
 */
package xop_pkg;
    typedef enum logic [3:0] {
        XOP_FETCH = 4'b0001,
        XOP_RETNOP = 4'b0010,
        XOP_CALLNOP = 4'b0100,
        XOP_MOVEWR = 4'b1000
    } xop_state_t;
endpackage : xop_pkg

// ===== logic/xop_phase_counter.sv
/*
 * Four-phase counter of the instruction cycle.
 * Assumes mclk is the phase clock and resetn the core reset.
 */
`include "xop_defines.svh"
module xop_phase_counter (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Phase
    output logic [1:0] phase,
    output logic lastPhase
);
    logic [1:0] phase_q;
    logic [1:0] phase_d;

    always_comb begin
        phase_d = phase_q + 2'd1;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 2'd0;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;
    assign lastPhase = (phase_q == `XOP_LAST_PHASE);
endmodule : xop_phase_counter

// ===== logic/xop_decoder.sv
/*
 * Decoder and executor of four extended instructions: pointer literal add,
 * add-and-return on the third pointer, call through the accumulator and
 * indexed-to-absolute move.
 * Assumes instruction words arrive stable for a whole four-phase cycle, the
 * data memory answers a read within the same phase, and the core ignores
 * these outputs when extInstr is low.
 */
`include "xop_defines.svh"
// How it works
// RQ1: Opcode e8 with select 0..2 adds 6-bit literal to that pointer, flags kept.
// RQ2: Pointer add is one word, one cycle, written in the last phase.
// RQ3: Select 11 adds literal to third pointer then returns from stack top.
// RQ4: Add-and-return takes two cycles; second is a no-operation.
// RQ5: Accumulator call first pushes program counter plus two.
// RQ6: Call loads counter low from accumulator, high and upper from latches.
// RQ7: Accumulator call takes two cycles; second is a no-operation.
// RQ8: Call never saves or alters accumulator, status or bank select.
// RQ9: Move source is third pointer plus 7-bit offset of first word.
// RQ10: Move destination is 12-bit absolute from second word starting 1111.
// RQ11: Software never targets counter low or stack top bytes with the move.
// RQ12: Source on an indirect register yields 00h with no indirect access.
// RQ13: Move: two words, two cycles, read first, write second, no dummy read.
// RQ14: Nothing is decoded unless the extended-set enable bit is one.
module xop_decoder (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Configuration
    input wire logic extendedSetEnable,
    // Program memory
    input wire logic [15:0] instrWord,
    input wire logic [20:0] programCounter,
    // Core registers
    input wire logic [7:0] accumulatorRegister,
    input wire logic [7:0] counterHighLatch,
    input wire logic [7:0] counterUpperLatch,
    input wire logic [11:0] filePointer0,
    input wire logic [11:0] filePointer1,
    input wire logic [11:0] thirdFilePointer,
    input wire logic [20:0] returnStackTop,
    // Data memory
    input wire logic [7:0] dataRdata,
    output logic [11:0] dataAddr,
    output logic dataRead,
    output logic dataWrite,
    output logic [7:0] dataWdata,
    // Pointer write
    output logic pointerWrite,
    output logic [1:0] pointerSel,
    output logic [11:0] pointerValue,
    // Program counter and return stack
    output logic pcLoad,
    output logic [20:0] pcValue,
    output logic stackPush,
    output logic [20:0] stackPushValue,
    // Status
    output logic extInstr,
    output logic [1:0] phase
);
    logic lastPhase;
    xop_phase_counter i_xop_phase_counter (
        .mclk(mclk),
        .resetn(resetn),
        .phase(phase),
        .lastPhase(lastPhase)
    );

    function automatic logic isIndirect(input logic [11:0] a);
        isIndirect = (a >= `XOP_IND_BASE0 && a < `XOP_IND_BASE0 + `XOP_IND_SPAN)
            || (a >= `XOP_IND_BASE1 && a < `XOP_IND_BASE1 + `XOP_IND_SPAN)
            || (a >= `XOP_IND_BASE2 && a < `XOP_IND_BASE2 + `XOP_IND_SPAN);
    endfunction : isIndirect

    xop_pkg::xop_state_t state_q, state_d;
    logic [7:0] moveData_q, moveData_d;

    // Decode only in fetch state and only with the enable set
    logic inFetch;
    logic isAdd, isRet, isCall, isMove;
    logic [11:0] srcAddr;
    logic [11:0] selPtr;
    assign inFetch = (state_q == xop_pkg::XOP_FETCH);
    assign isAdd = inFetch && extendedSetEnable && instrWord[15:8] == `XOP_OPC_ADDPTR
        && instrWord[7:6] != `XOP_SEL_RETURN; // [RQ14] [RQ1]
    assign isRet = inFetch && extendedSetEnable && instrWord[15:8] == `XOP_OPC_ADDPTR
        && instrWord[7:6] == `XOP_SEL_RETURN; // [RQ3]
    assign isCall = inFetch && extendedSetEnable && instrWord == `XOP_OPC_CALLACC; // [RQ14]
    assign isMove = inFetch && extendedSetEnable && instrWord[15:8] == `XOP_OPC_MOVE
        && !instrWord[7]; // [RQ9]
    assign srcAddr = thirdFilePointer + {5'd0, instrWord[6:0]}; // [RQ9]

    always_comb begin
        unique case (instrWord[7:6])
            2'd0: selPtr = filePointer0;
            2'd1: selPtr = filePointer1;
            default: selPtr = thirdFilePointer;
        endcase
    end

    always_comb begin
        state_d = state_q;
        moveData_d = moveData_q;
        if (lastPhase) begin
            unique case (state_q)
                xop_pkg::XOP_FETCH: begin
                    if (isRet) state_d = xop_pkg::XOP_RETNOP; // [RQ4]
                    else if (isCall) state_d = xop_pkg::XOP_CALLNOP; // [RQ7]
                    else if (isMove) begin
                        state_d = xop_pkg::XOP_MOVEWR; // [RQ13]
                        moveData_d = isIndirect(srcAddr) ? `XOP_INDIRECT_VALUE
                            : dataRdata; // [RQ12]
                    end
                end
                default: state_d = xop_pkg::XOP_FETCH;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= xop_pkg::XOP_FETCH;
            moveData_q <= 8'h00;
        end else begin
            state_q <= state_d;
            moveData_q <= moveData_d;
        end
    end

    // Source read in last phase of first cycle; indirect source never read
    assign dataRead = isMove && lastPhase && !isIndirect(srcAddr); // [RQ12] [RQ13]
    // Destination from second word; software keeps it off counter/stack bytes
    assign dataWrite = (state_q == xop_pkg::XOP_MOVEWR) && lastPhase
        && instrWord[15:12] == `XOP_SECOND_NIBBLE; // [RQ10] [RQ11] [RQ13]
    assign dataAddr = (state_q == xop_pkg::XOP_MOVEWR) ? instrWord[11:0] : srcAddr; // [RQ10]
    assign dataWdata = moveData_q;

    // Pointer add, flags untouched (no status output exists)
    assign pointerWrite = (isAdd || isRet) && lastPhase; // [RQ2] [RQ1] [RQ3]
    assign pointerSel = isRet ? 2'd2 : instrWord[7:6]; // [RQ3]
    assign pointerValue = selPtr + {6'd0, instrWord[5:0]}; // [RQ1]

    // Return and call; accumulator, status and bank select never written
    assign stackPush = isCall && lastPhase; // [RQ5] [RQ8]
    assign stackPushValue = programCounter + `XOP_PC_STEP; // [RQ5]
    assign pcLoad = (isRet || isCall) && lastPhase; // [RQ3] [RQ6]
    assign pcValue = isCall ? {counterUpperLatch[4:0], counterHighLatch, accumulatorRegister}
        : returnStackTop; // [RQ6]
    assign extInstr = isAdd || isRet || isCall || isMove || !inFetch;

    property p_add_one_cycle;
        @(posedge mclk) disable iff (!resetn)
        (isAdd && lastPhase) |=> state_q == xop_pkg::XOP_FETCH;
    endproperty
    a_add_one_cycle: assert property (p_add_one_cycle) else $error("add took extra cycle"); // [RQ2]

    property p_ret_two;
        @(posedge mclk) disable iff (!resetn)
        (isRet && lastPhase) |=> (state_q == xop_pkg::XOP_RETNOP && !pointerWrite)[*4]
            ##1 state_q == xop_pkg::XOP_FETCH;
    endproperty
    a_ret_two: assert property (p_ret_two) else $error("return nop cycle wrong"); // [RQ4]

    property p_call_push;
        @(posedge mclk) disable iff (!resetn)
        stackPush |-> pcLoad && stackPushValue == programCounter + `XOP_PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong"); // [RQ5]

    property p_call_nop;
        @(posedge mclk) disable iff (!resetn)
        stackPush |=> (!stackPush && !pcLoad)[*4];
    endproperty
    a_call_nop: assert property (p_call_nop) else $error("call second cycle active"); // [RQ7]

    property p_enable;
        @(posedge mclk) disable iff (!resetn)
        (!extendedSetEnable && inFetch) |-> !pointerWrite && !pcLoad && !dataRead;
    endproperty
    a_enable: assert property (p_enable) else $error("decode while disabled"); // [RQ14]

    property p_indirect;
        @(posedge mclk) disable iff (!resetn)
        (isMove && lastPhase && isIndirect(srcAddr)) |=> moveData_q == `XOP_INDIRECT_VALUE;
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect source not zero"); // [RQ12]

    property p_move_write;
        @(posedge mclk) disable iff (!resetn)
        (isMove && lastPhase) |=> (!dataRead)[*3]
            ##1 (!dataRead && dataWdata == $past(moveData_q));
    endproperty
    a_move_write: assert property (p_move_write) else $error("dummy read in move"); // [RQ13]

    property p_ret_ptr;
        @(posedge mclk) disable iff (!resetn)
        (isRet && lastPhase) |-> pointerSel == 2'd2 && pcValue == returnStackTop;
    endproperty
    a_ret_ptr: assert property (p_ret_ptr) else $error("return pointer wrong"); // [RQ3]
endmodule : xop_decoder

// ===== verification/xop_far_side_model.sv
/*
 * Far-side model: data memory and a one-level return stack.
 * Assumes the decoder pulses its strobes for one rising edge of mclk.
 */
module xop_far_side_model (
    // Clock
    input wire logic mclk,
    // Data memory
    input wire logic [11:0] dataAddr,
    input wire logic dataRead,
    input wire logic dataWrite,
    input wire logic [7:0] dataWdata,
    output logic [7:0] dataRdata,
    // Return stack
    input wire logic stackPush,
    input wire logic [20:0] stackPushValue,
    output logic [20:0] returnStackTop
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [4096];
    logic [7:0] lastQ;
    initial begin
        lastQ = 8'h00;
        returnStackTop = 21'h01a2b4;
        for (int a = 0; a < 4096; a++) begin
            mem[a] = a[7:0] ^ 8'h5a;
        end
    end
    // Idle bus shows the inverse of the last read, so stale data never passes
    assign dataRdata = dataRead ? mem[dataAddr] : ~lastQ;
    always @(posedge mclk) begin
        if (dataRead) begin
            lastQ <= mem[dataAddr];
        end
        if (dataWrite) begin
            mem[dataAddr] <= dataWdata;
        end
        if (stackPush) begin
            returnStackTop <= stackPushValue;
        end
    end
endmodule : xop_far_side_model

// ===== verification/extended_pointer_call_move_ops_tb_top.sv
/*
 * Self-checking bench for the extended-op decoder.
 * Assumes the far-side model is compiled before it.
 */
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin nFail++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module extended_pointer_call_move_ops_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, resetn, ena, early, rd, wr, ptrWr, pcLoad, push, ext;
    logic [15:0] w;
    logic [20:0] pc, return_stack_top, pcValue, pushVal;
    logic [7:0] acc, hiL, upL, rdata, wdata;
    logic [11:0] fp0, fp1, fp2, addr, ptrVal;
    logic [1:0] ptrSel, phase;
    int nFail = 0;
    int testsRun = 0;
    xop_decoder i_xop_decoder (.mclk(mclk), .resetn(resetn), .extendedSetEnable(ena),
        .instrWord(w), .programCounter(pc), .accumulatorRegister(acc), .counterHighLatch(hiL),
        .counterUpperLatch(upL), .filePointer0(fp0), .filePointer1(fp1), .thirdFilePointer(fp2),
        .returnStackTop(return_stack_top), .dataRdata(rdata), .dataAddr(addr), .dataRead(rd), .dataWrite(wr),
        .dataWdata(wdata), .pointerWrite(ptrWr), .pointerSel(ptrSel), .pointerValue(ptrVal),
        .pcLoad(pcLoad), .pcValue(pcValue), .stackPush(push), .stackPushValue(pushVal),
        .extInstr(ext), .phase(phase));
    xop_far_side_model i_xop_far_side_model (.mclk(mclk), .dataAddr(addr), .dataRead(rd),
        .dataWrite(wr), .dataWdata(wdata), .dataRdata(rdata), .stackPush(push),
        .stackPushValue(pushVal), .returnStackTop(return_stack_top));
    task automatic completeRun;
        if (nFail == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : completeRun
    // Entered and left at a falling edge in phase 3; the word changes only in
    // phase 0, so the previous cycle's last edge never decodes it
    task automatic step(input logic [15:0] word);
        @(negedge mclk);
        w = word;
        early = 1'b0;
        repeat (2) begin
            @(negedge mclk);
            early = early | ptrWr | pcLoad | push | rd | wr;
        end
        @(negedge mclk);
        `CHK(early, 1'b0)
        `CHK(phase, 2'd3)
    endtask : step
    task automatic pulses(input logic [4:0] e, input logic x);
        `CHK({ptrWr, pcLoad, push, rd, wr}, e)
        `CHK(ext, x)
    endtask : pulses
    task automatic testDisabled;
        ena = 1'b0;
        step(16'he83f);
        pulses(5'h00, 1'b0);
        // Clear the word first so the enable never meets it in a last phase
        w = 16'h0000;
        ena = 1'b1;
    endtask : testDisabled
    task automatic testAdd;
        for (int s = 0; s < 3; s++) begin
            step({8'he8, s[1:0], 6'h3f});
            pulses(5'h10, 1'b1);
            `CHK(ptrSel, s[1:0])
            `CHK(ptrVal, (s == 0 ? fp0 : s == 1 ? fp1 : fp2) + 12'h03f)
        end
    endtask : testAdd
    task automatic testCall;
        step(16'h0014);
        pulses(5'h0c, 1'b1);
        `CHK(pushVal, pc + 21'h000002)
        `CHK(pcValue, {upL[4:0], hiL, acc})
        step(16'h0000);
        pulses(5'h00, 1'b1);
    endtask : testCall
    task automatic testReturn;
        step(16'he8c5);
        pulses(5'h18, 1'b1);
        `CHK(ptrSel, 2'd2)
        `CHK(ptrVal, fp2 + 12'h005)
        `CHK(pcValue, pc + 21'h000002)
        // Same word again must not decode: second cycle is idle
        step(16'he8c5);
        pulses(5'h00, 1'b1);
    endtask : testReturn
    task automatic testMove(input logic [6:0] z, input logic [11:0] dst, input logic r,
            input logic [7:0] d);
        step({9'h1d6, z});
        `CHK({rd, wr}, {r, 1'b0})
        `CHK(ext, 1'b1)
        if (r) `CHK(addr, fp2 + {5'h00, z})
        step({4'hf, dst});
        `CHK({rd, wr}, 2'b01)
        `CHK(addr, dst)
        `CHK(wdata, d)
    endtask : testMove
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        resetn = 1'b0;
        ena = 1'b1;
        w = 16'h0000;
        pc = 21'h000100;
        acc = 8'h06;
        hiL = 8'h10;
        upL = 8'he3;
        fp0 = 12'h0ff;
        fp1 = 12'hfd0;
        fp2 = 12'h3ff;
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        for (int i = 0; i < 8 && phase !== 2'd3; i++) @(negedge mclk);
        if (phase !== 2'd3) begin
            nFail++;
        end else begin
            testDisabled();
            testAdd();
            testCall();
            testReturn();
            fp2 = 12'h080;
            testMove(7'h05, 12'h200, 1'b1, 8'h85 ^ 8'h5a);
            fp2 = 12'hfe0;
            testMove(7'h0f, 12'h123, 1'b0, 8'h00);
            testMove(7'h07, 12'h124, 1'b0, 8'h00);
        end
        completeRun();
    end
endmodule : extended_pointer_call_move_ops_tb_top
